/* fbios_cfg.svh */
`ifndef FBIOS_CFG_SVH
`define FBIOS_CFG_SVH
// Connection slots and slot index width
`define FBIOS_SLOTS 8
`define FBIOS_SLOT_W 3
// Register numbers
`define FBIOS_REG_CMD 16'h07d6
`define FBIOS_REG_STAT 16'h1f3c
`define FBIOS_REG_DIAG 16'h1f3d
`define FBIOS_REG_IN 16'h1f40
// Function codes
`define FBIOS_FC_RD_COIL 8'h01
`define FBIOS_FC_RD_DISC 8'h02
`define FBIOS_FC_RD_HOLD 8'h03
`define FBIOS_FC_RD_INP 8'h04
`define FBIOS_FC_WR_COIL 8'h05
`define FBIOS_FC_WR_REG 8'h06
`define FBIOS_FC_WR_COILS 8'h0f
`define FBIOS_FC_WR_REGS 8'h10
`define FBIOS_FC_RW_REGS 8'h17
// Exception codes
`define FBIOS_EXC_NONE 8'h00
`define FBIOS_EXC_FUNC 8'h01
`define FBIOS_EXC_ADDR 8'h02
`define FBIOS_EXC_VALUE 8'h03
// Command and diagnostic bit positions
`define FBIOS_CMD_CLEAR 16'h0080
`define FBIOS_DIAG_UV 2
`define FBIOS_DIAG_SHORT 4
`define FBIOS_DIAG_TEMP 10
`define FBIOS_STAT_ERR 0
// Reset values
`define FBIOS_RST_WORD 16'h0000
`define FBIOS_RST_CODE 8'h00
`endif

/* fbios_client.sv */
`include "fbios_cfg.svh"
// Client side: opens and drops connections, issues one request per call
module fbios_client (
  input wire logic core_clk,
  input wire logic open_ack,
  input wire logic open_full,
  input wire logic [`FBIOS_SLOT_W-1:0] open_slot,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_exc,
  input wire logic [7:0] rsp_code,
  output logic open_req = 1'b0,
  output logic close_req = 1'b0,
  output logic [`FBIOS_SLOT_W-1:0] close_slot = 3'h7,
  output logic req_valid = 1'b0,
  output logic [`FBIOS_SLOT_W-1:0] req_slot = 3'h7,
  output logic [7:0] req_fc = 8'hff,
  output logic [15:0] req_addr = 16'hffff,
  output logic [15:0] req_waddr = 16'hffff,
  output logic [15:0] req_wdata = 16'hffff
);
  timeunit 1ns;
  timeprecision 1ps;
  // One connection event, answer sampled after the taking edge settles
  task automatic link(input logic op, input logic cl, input logic [2:0] cs,
                      output logic ack, output logic full, output logic [2:0] slot);
    @(posedge core_clk);
    open_req <= op;
    close_req <= cl;
    close_slot <= cs;
    @(posedge core_clk);
    open_req <= 1'b0;
    close_req <= 1'b0;
    close_slot <= ~cs; // Released select shows a changed value
    #1;
    ack = open_ack;
    full = open_full;
    slot = open_slot;
  endtask
  // One request pulse; released fields except req_slot are inverted so stale data never matches
  task automatic xfer(input logic [2:0] s, input logic [7:0] fc, input logic [15:0] a,
                      input logic [15:0] wa, input logic [15:0] wd, output logic got,
                      output logic [15:0] data, output logic exc, output logic [7:0] code);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_slot <= s;
    req_fc <= fc;
    req_addr <= a;
    req_waddr <= wa;
    req_wdata <= wd;
    @(posedge core_clk);
    req_valid <= 1'b0;
    req_fc <= ~fc;
    req_addr <= ~a;
    req_waddr <= ~wa;
    req_wdata <= ~wd;
    #1;
    got = rsp_valid;
    data = rsp_data;
    exc = rsp_exc;
    code = rsp_code;
  endtask
endmodule // fbios_client

/* fbios_pkg.sv */
`include "fbios_cfg.svh"
package fbios_pkg;
  // Latched diagnostic conditions: undervoltage, short, overtemperature
  typedef struct packed {
    logic uv;
    logic shrt;
    logic temp;
  } fbios_diag_t;

  // Whole state of the register server
  typedef struct packed {
    logic [`FBIOS_SLOTS-1:0] live;
    fbios_diag_t diag;
    logic cmd_err;
    logic err_flag;
    logic [15:0] diag_word;
    logic rsp_valid;
    logic [`FBIOS_SLOT_W-1:0] rsp_slot;
    logic [15:0] rsp_data;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic open_ack;
    logic open_full;
    logic [`FBIOS_SLOT_W-1:0] open_slot;
  } fbios_state_t;
endpackage

/* fbios_server.sv */
`include "fbios_cfg.svh"
// Overview of operation
// RULE1: Up to eight client connections live at once, each addressing registers independently.
// RULE2: A dropped connection may reopen in any free slot to resume access.
// RULE3: Function codes 1,2,3,4,5,6,15,16,23 decoded; all others answer exception 01.
// RULE4: Class 0 (word read, multi-word write) complete; class 1/2 only partly.
// RULE5: Input word at 8000 readable by codes 1,2,3,4 and 23.
// RULE6: Writes to 7996, 7997 or 8000 are dropped with exception 02.
// RULE7: Command word 2006 is write-only via codes 6, 16, 23; reads refused.
// RULE8: Command write with more than one bit set reports an error.
// RULE9: Command value 0080 alone clears latched supply and temperature warnings.
// RULE10: Status bit 0 high while any diagnostic bit is set, else zero.
// RULE11: Diagnostic bits: 2 undervoltage, 4 short/overload, 10 overtemperature.
// RULE12: Inputs 1-8 in byte 0, 9-16 in byte 1, lowest input at bit 0.
// RULE13: Words are sent high byte first and mapped one to one.
// RULE14: Reserved single-bit commands are ignored; status falls after clear with no fault.
module fbios_server import fbios_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [15:0] din,
  input wire logic ev_uv,
  input wire logic ev_short,
  input wire logic ev_temp,
  input wire logic open_req,
  input wire logic close_req,
  input wire logic [`FBIOS_SLOT_W-1:0] close_slot,
  input wire logic req_valid,
  input wire logic [`FBIOS_SLOT_W-1:0] req_slot,
  input wire logic [7:0] req_fc,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_waddr,
  input wire logic [15:0] req_wdata,
  output logic open_ack,
  output logic open_full,
  output logic [`FBIOS_SLOT_W-1:0] open_slot,
  output logic [`FBIOS_SLOTS-1:0] live_mask,
  output logic rsp_valid,
  output logic [`FBIOS_SLOT_W-1:0] rsp_slot,
  output logic [15:0] rsp_data,
  output logic rsp_exc,
  output logic [7:0] rsp_code,
  output logic cmd_err,
  output logic err_flag,
  output logic [15:0] diag_word
);
  fbios_state_t s_q, s_d;

  // Read-only register test
  function automatic logic is_ro(input logic [15:0] a);
    is_ro = (a == `FBIOS_REG_STAT) || (a == `FBIOS_REG_DIAG) || (a == `FBIOS_REG_IN);
  endfunction

  // More than one bit set
  function automatic logic multi_bit(input logic [15:0] w);
    multi_bit = (w & (w - 16'h0001)) != `FBIOS_RST_WORD;
  endfunction

  // Diagnostic word from latched conditions
  function automatic logic [15:0] diag_of(input fbios_diag_t d);
    logic [15:0] w;
    w = `FBIOS_RST_WORD;
    w[`FBIOS_DIAG_UV] = d.uv; // RULE11
    w[`FBIOS_DIAG_SHORT] = d.shrt; // RULE11
    w[`FBIOS_DIAG_TEMP] = d.temp; // RULE11
    diag_of = w;
  endfunction

  logic clr;
  logic wr_bad;
  logic [15:0] rd_word;
  logic rd_ok;
  logic found;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.open_ack = 1'b0;
    s_d.open_full = 1'b0;
    clr = 1'b0;
    wr_bad = 1'b0;
    rd_word = `FBIOS_RST_WORD;
    rd_ok = 1'b0;
    found = 1'b0;
    // Open: lowest free slot takes the new connection
    if (open_req) begin
      for (int i = 0; i < `FBIOS_SLOTS; i++) begin
        if (!found && !s_q.live[i]) begin
          found = 1'b1;
          s_d.live[i] = 1'b1; // RULE1 RULE2
          s_d.open_slot = i[`FBIOS_SLOT_W-1:0];
        end
      end
      s_d.open_ack = found;
      s_d.open_full = !found; // RULE1
    end
    // Close frees the slot for a later reconnect
    if (close_req) begin
      s_d.live[close_slot] = 1'b0; // RULE2
    end
    // Word read decode; command word is not readable
    if (req_addr == `FBIOS_REG_STAT) begin
      rd_word[`FBIOS_STAT_ERR] = s_q.err_flag; // RULE10
      rd_ok = 1'b1;
    end else if (req_addr == `FBIOS_REG_DIAG) begin
      rd_word = s_q.diag_word;
      rd_ok = 1'b1;
    end else if (req_addr == `FBIOS_REG_IN) begin
      rd_word = din; // RULE12
      rd_ok = 1'b1;
    end
    // Request handling, one answer per taken request
    if (req_valid && s_q.live[req_slot]) begin // RULE1
      s_d.rsp_valid = 1'b1;
      s_d.rsp_slot = req_slot;
      s_d.rsp_exc = 1'b0;
      s_d.rsp_code = `FBIOS_EXC_NONE;
      s_d.rsp_data = `FBIOS_RST_WORD;
      case (req_fc)
        `FBIOS_FC_RD_COIL, `FBIOS_FC_RD_DISC: begin
          if (req_addr == `FBIOS_REG_IN) begin
            s_d.rsp_data = din; // RULE5 RULE12
          end else begin
            s_d.rsp_exc = 1'b1;
            s_d.rsp_code = `FBIOS_EXC_ADDR;
          end
        end
        `FBIOS_FC_RD_HOLD, `FBIOS_FC_RD_INP: begin
          if (rd_ok) begin
            s_d.rsp_data = rd_word; // RULE4 RULE5 RULE13
          end else begin
            s_d.rsp_exc = 1'b1;
            s_d.rsp_code = `FBIOS_EXC_ADDR; // RULE7
          end
        end
        `FBIOS_FC_WR_COIL, `FBIOS_FC_WR_COILS: begin
          s_d.rsp_exc = 1'b1;
          s_d.rsp_code = `FBIOS_EXC_ADDR; // RULE6
        end
        `FBIOS_FC_WR_REG, `FBIOS_FC_WR_REGS, `FBIOS_FC_RW_REGS: begin
          // Read part, then write part for combined access
          if (req_fc == `FBIOS_FC_RW_REGS && !rd_ok) begin
            s_d.rsp_exc = 1'b1;
            s_d.rsp_code = `FBIOS_EXC_ADDR; // RULE7
          end else if ((req_fc == `FBIOS_FC_RW_REGS ? req_waddr : req_addr)
                       == `FBIOS_REG_CMD) begin
            if (multi_bit(req_wdata)) begin
              wr_bad = 1'b1;
              s_d.cmd_err = 1'b1; // RULE8
              s_d.rsp_exc = 1'b1;
              s_d.rsp_code = `FBIOS_EXC_VALUE; // RULE8
            end else begin
              s_d.cmd_err = 1'b0;
              clr = (req_wdata == `FBIOS_CMD_CLEAR); // RULE9 RULE14
              s_d.rsp_data = (req_fc == `FBIOS_FC_RW_REGS) ? rd_word : req_wdata; // RULE13
            end
          end else begin
            // Read-only or unmapped target: data discarded
            s_d.rsp_exc = 1'b1;
            s_d.rsp_code = `FBIOS_EXC_ADDR; // RULE6
          end
        end
        default: begin
          s_d.rsp_exc = 1'b1;
          s_d.rsp_code = `FBIOS_EXC_FUNC; // RULE3
        end
      endcase
    end
    // Latched conditions; a new event wins over the clear
    s_d.diag.uv = (s_q.diag.uv & ~clr) | ev_uv; // RULE9
    s_d.diag.shrt = (s_q.diag.shrt & ~clr) | ev_short;
    s_d.diag.temp = (s_q.diag.temp & ~clr) | ev_temp;
    s_d.diag_word = diag_of(s_d.diag); // RULE11
    s_d.err_flag = s_d.diag.uv | s_d.diag.shrt | s_d.diag.temp; // RULE10 RULE14
  end

  // State register with clock enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign open_ack = s_q.open_ack;
  assign open_full = s_q.open_full;
  assign open_slot = s_q.open_slot;
  assign live_mask = s_q.live;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_slot = s_q.rsp_slot;
  assign rsp_data = s_q.rsp_data;
  assign rsp_exc = s_q.rsp_exc;
  assign rsp_code = s_q.rsp_code;
  assign cmd_err = s_q.cmd_err;
  assign err_flag = s_q.err_flag;
  assign diag_word = s_q.diag_word;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic taken;
  assign taken = ce && req_valid && s_q.live[req_slot];

  unsup_fc_a: assert property ( // RULE3
      taken && !(req_fc inside {`FBIOS_FC_RD_COIL, `FBIOS_FC_RD_DISC, `FBIOS_FC_RD_HOLD,
      `FBIOS_FC_RD_INP, `FBIOS_FC_WR_COIL, `FBIOS_FC_WR_REG, `FBIOS_FC_WR_COILS,
      `FBIOS_FC_WR_REGS, `FBIOS_FC_RW_REGS})
      |=> rsp_valid && rsp_exc && rsp_code == `FBIOS_EXC_FUNC)
    else $error("unsupported code not refused");
  ro_write_a: assert property ( // RULE6
      taken && req_fc == `FBIOS_FC_WR_REG && is_ro(req_addr) && !ev_uv && !ev_short && !ev_temp
      |=> rsp_exc && rsp_code == `FBIOS_EXC_ADDR && $stable(diag_word))
    else $error("read-only write not refused");
  cmd_read_a: assert property ( // RULE7
      taken && req_fc == `FBIOS_FC_RD_HOLD && req_addr == `FBIOS_REG_CMD
      |=> rsp_exc && rsp_code == `FBIOS_EXC_ADDR)
    else $error("command word readable");
  multi_bit_a: assert property ( // RULE8
      taken && req_fc == `FBIOS_FC_WR_REG && req_addr == `FBIOS_REG_CMD
      && $countones(req_wdata) > 1 |=> cmd_err && rsp_code == `FBIOS_EXC_VALUE)
    else $error("multi-bit command not flagged");
  clear_cmd_a: assert property ( // RULE9 RULE14
      taken && req_fc == `FBIOS_FC_WR_REG && req_addr == `FBIOS_REG_CMD
      && req_wdata == `FBIOS_CMD_CLEAR && !ev_uv && !ev_short && !ev_temp
      |=> !err_flag && diag_word == `FBIOS_RST_WORD)
    else $error("clear command did not clear");
  status_sum_a: assert property (err_flag == (diag_word != `FBIOS_RST_WORD)) // RULE10
    else $error("status bit disagrees with diagnosis");
  diag_map_a: assert property ( // RULE11
      ce && ev_temp |=> diag_word[`FBIOS_DIAG_TEMP] && err_flag)
    else $error("overtemperature not latched");
  input_map_a: assert property ( // RULE5 RULE12
      taken && req_fc == `FBIOS_FC_RD_INP && req_addr == `FBIOS_REG_IN
      |=> !rsp_exc && rsp_data == $past(din))
    else $error("input word mismatch");
  dead_slot_a: assert property ( // RULE1
      ce && req_valid && !s_q.live[req_slot] && !rsp_valid |=> !rsp_valid)
    else $error("request on closed slot answered");
  full_open_a: assert property ( // RULE1 RULE2
      ce && open_req && (&live_mask) |=> open_full && !open_ack)
    else $error("open beyond slot count");

  clear_c: cover property (taken && req_wdata == `FBIOS_CMD_CLEAR ##1 !err_flag);
  reopen_c: cover property (ce && close_req ##1 ce && open_req ##1 open_ack);
  rw23_c: cover property (taken && req_fc == `FBIOS_FC_RW_REGS ##1 rsp_valid && !rsp_exc);
endmodule // fbios_server

/* test_fieldbus_io_register_server.sv */
`include "fbios_cfg.svh"
module test_fieldbus_io_register_server;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] din = 16'h0000;
  logic ev_uv = 1'b0;
  logic ev_short = 1'b0;
  logic ev_temp = 1'b0;
  logic ce = 1'b1;
  logic open_req, close_req, req_valid, open_ack, open_full, rsp_valid, rsp_exc;
  logic cmd_err, err_flag, ack, full, got, exc;
  logic [2:0] close_slot, req_slot, open_slot, rsp_slot, slot;
  logic [7:0] req_fc, rsp_code, live_mask, code;
  logic [15:0] req_addr, req_waddr, req_wdata, rsp_data, diag_word, data;
  logic [7:0] rd_fc [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h17};
  logic [7:0] wr_fc [4] = '{8'h05, 8'h06, 8'h0f, 8'h10};
  logic [15:0] ro_reg [3] = '{16'h1f3c, 16'h1f3d, 16'h1f40};
  int fail_count = 0;
  int cmp_count = 0;
  // Clock, 40 ns period
  always #20 core_clk = ~core_clk;
  fbios_server u_fbios_server (.core_clk(core_clk), .rstn(rstn), .ce(ce), .din(din),
    .ev_uv(ev_uv), .ev_short(ev_short), .ev_temp(ev_temp), .open_req(open_req),
    .close_req(close_req), .close_slot(close_slot), .req_valid(req_valid),
    .req_slot(req_slot), .req_fc(req_fc), .req_addr(req_addr), .req_waddr(req_waddr),
    .req_wdata(req_wdata), .open_ack(open_ack), .open_full(open_full),
    .open_slot(open_slot), .live_mask(live_mask), .rsp_valid(rsp_valid),
    .rsp_slot(rsp_slot), .rsp_data(rsp_data), .rsp_exc(rsp_exc), .rsp_code(rsp_code),
    .cmd_err(cmd_err), .err_flag(err_flag), .diag_word(diag_word));
  fbios_client u_fbios_client (.core_clk(core_clk), .open_ack(open_ack),
    .open_full(open_full), .open_slot(open_slot), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_exc(rsp_exc), .rsp_code(rsp_code), .open_req(open_req),
    .close_req(close_req), .close_slot(close_slot), .req_valid(req_valid),
    .req_slot(req_slot), .req_fc(req_fc), .req_addr(req_addr), .req_waddr(req_waddr),
    .req_wdata(req_wdata));
  // Compare one value, count and report
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // Request with expected answer word and exception code
  task automatic rq(input logic [2:0] s, input logic [7:0] fc, input logic [15:0] a,
                    input logic [15:0] wa, input logic [15:0] wd, input logic [15:0] ed,
                    input logic [7:0] ec);
    u_fbios_client.xfer(s, fc, a, wa, wd, got, data, exc, code);
    chk("answer", 16'h0001, {15'h0000, got});
    chk("slot", {13'h0000, s}, {13'h0000, rsp_slot});
    chk("code", {8'h00, ec}, {8'h00, code});
    chk("exc", {15'h0000, ec != 8'h00}, {15'h0000, exc});
    if (ec == 8'h00) chk("data", ed, data);
  endtask
  // Counts, verdict and end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    din <= 16'ha5c3;
    for (int i = 0; i < 8; i++) begin
      u_fbios_client.link(1'b1, 1'b0, 3'h0, ack, full, slot);
      chk("grant", {13'h0000, 3'(i)}, {13'h0000, slot});
      chk("ack", 16'h0001, {15'h0000, ack});
    end
    chk("live", 16'h00ff, {8'h00, live_mask});
    u_fbios_client.link(1'b1, 1'b0, 3'h0, ack, full, slot);
    chk("full", 16'h0001, {15'h0000, full});
    chk("ack", 16'h0000, {15'h0000, ack});
    u_fbios_client.link(1'b0, 1'b1, 3'h3, ack, full, slot);
    chk("live", 16'h00f7, {8'h00, live_mask});
    u_fbios_client.link(1'b1, 1'b0, 3'h0, ack, full, slot);
    chk("regrant", 16'h0003, {13'h0000, slot});
    chk("ack", 16'h0001, {15'h0000, ack});
    chk("full", 16'h0000, {15'h0000, full});
    u_fbios_client.link(1'b0, 1'b1, 3'h5, ack, full, slot);
    chk("live", 16'h00df, {8'h00, live_mask});
    u_fbios_client.xfer(3'h5, 8'h03, 16'h1f40, 16'h0000, 16'h0000, got, data, exc, code);
    chk("dead", 16'h0000, {15'h0000, got});
    for (int i = 0; i < 5; i++) begin
      rq(3'(i), rd_fc[i], 16'h1f40, 16'h07d6, 16'h0001, 16'ha5c3, 8'h00);
    end
    rq(3'h0, 8'h07, 16'h1f40, 16'h0000, 16'h0000, 16'h0000, 8'h01);
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        rq(3'h1, wr_fc[i], ro_reg[j], 16'h0000, 16'h0080, 16'h0000, 8'h02);
      end
    end
    rq(3'h1, 8'h03, 16'h07d6, 16'h0000, 16'h0000, 16'h0000, 8'h02);
    rq(3'h1, 8'h04, 16'h07d6, 16'h0000, 16'h0000, 16'h0000, 8'h02);
    @(posedge core_clk);
    ev_uv <= 1'b1;
    ev_short <= 1'b1;
    ev_temp <= 1'b1;
    @(posedge core_clk);
    ev_uv <= 1'b0;
    ev_short <= 1'b0;
    ev_temp <= 1'b0;
    rq(3'h2, 8'h03, 16'h1f3d, 16'h0000, 16'h0000, 16'h0414, 8'h00);
    rq(3'h2, 8'h04, 16'h1f3c, 16'h0000, 16'h0000, 16'h0001, 8'h00);
    rq(3'h3, 8'h06, 16'h07d6, 16'h0000, 16'h0081, 16'h0000, 8'h03);
    chk("cmd_err", 16'h0001, {15'h0000, cmd_err});
    rq(3'h3, 8'h10, 16'h07d6, 16'h0000, 16'h0001, 16'h0001, 8'h00);
    chk("diag", 16'h0414, diag_word);
    rq(3'h4, 8'h17, 16'h1f40, 16'h07d6, 16'h0080, 16'ha5c3, 8'h00);
    chk("diag", 16'h0000, diag_word);
    chk("err_flag", 16'h0000, {15'h0000, err_flag});
    chk("cmd_err", 16'h0000, {15'h0000, cmd_err});
    // Clock enable low: neither the request nor the event is taken
    @(posedge core_clk);
    ce <= 1'b0;
    u_fbios_client.xfer(3'h0, 8'h04, 16'h1f40, 16'h0000, 16'h0000, got, data, exc, code);
    chk("frozen", 16'h0000, {15'h0000, got});
    @(posedge core_clk);
    ev_temp <= 1'b1;
    @(posedge core_clk);
    ev_temp <= 1'b0;
    ce <= 1'b1;
    rq(3'h0, 8'h04, 16'h1f40, 16'h0000, 16'h0000, 16'ha5c3, 8'h00);
    chk("frozen diag", 16'h0000, diag_word);
    chk("frozen err", 16'h0000, {15'h0000, err_flag});
    conclude();
  end
  // Watchdog well beyond the roughly 105 cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule // test_fieldbus_io_register_server
